/* dowd_defines.svh */
// Constants for the device options word decoder: offsets, bit positions, reset values.
// Assumes inclusion by the package, the decoder and the test bench.
`ifndef DOWD_DEFINES_SVH
`define DOWD_DEFINES_SVH
// ==========================================
// Register offsets
`define DOWD_OPT_WORD_OFFS 8'h00
`define DOWD_CONTROL_OFFS 8'h04
`define DOWD_STATUS_OFFS 8'h08
// ==========================================
// Option word layout
`define DOWD_WORD_W 24
`define DOWD_REF_LOC_BIT 4
`define DOWD_KEY_WIPE_BIT 3
`define DOWD_TAMPER_INPUT_PIN_DIS_BIT 2
`define DOWD_CMP_LOC_BIT 1
`define DOWD_IMPL_MASK 24'h00001E
`define DOWD_UNIMPL_ONES 24'hFFFFE1
`define DOWD_ERASED_WORD 24'hFFFFFF
// ==========================================
// AXI responses
`define DOWD_RESP_OKAY 2'h0
`define DOWD_RESP_SLVERR 2'h2
`endif

/* dowd_pkg.sv */
// Types shared by the options word decoder.
// Assumes the defines header sits in the same folder.
`include "dowd_defines.svh"
package dowd_pkg;
  // ==========================================
  // Decoded controls and latch states
  typedef struct packed {
    logic ref_on_alt_pins;
    logic key_wipe_enable;
    logic tamper_pin_enable;
    logic cmp_on_default_pins;
  } dowd_ctrl_t;
  typedef enum logic [1:0] {
    DOWD_ST_LOAD = 2'b00,
    DOWD_ST_RUN = 2'b01,
    DOWD_ST_WIPE = 2'b10
  } dowd_state_t;
endpackage

/* dowd_decoder.sv */
// Options word decoder: latches the one-time word, drives routing and tamper controls.
// Assumes nvm_word is stable at the first aclk edge after aresetn rises and an AXI4-Lite master on aclk.
//
// How it works
// R1: Unimplemented bits 23..5 and bit 0 always read back as one.
// R2: Bit 4 high routes references to RA10/RA9, low to RB0/RB1.
// R3: Bit 3 low erases key RAM on a tamper pin event; high keeps it.
// R4: Bit 2 high disables the tamper input pin, low enables it.
// R5: Bit 1 high keeps comparator C inputs default, low maps them to RG9.
// R6: Option bits readable, program once, erased value one; never rewritten.
// R7: Smallest package ignores bit 4; programmer keeps it zero there. The code has no package input and always decodes bit 4.
// R8: Word latched during reset; decoded controls held until next reset. The code latches it on the first aclk edge after aresetn rises.
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "dowd_defines.svh"
module dowd_decoder (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [23:0] nvm_word,
  input wire logic tamper_pin_raw,
  output dowd_pkg::dowd_ctrl_t ctrl,
  output logic tamper_pin_in_use,
  output logic key_ram_erase,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import dowd_pkg::*;
  // ==========================================
  // Word latch
  logic [23:0] word_q, word_d;
  dowd_state_t st_q, st_d;
  logic [2:0] tp_sync_q, tp_sync_d;
  logic tp_level_q, tp_level_d;
  logic tamper_seen_q, tamper_seen_d;
  logic wipe_ack_q, wipe_ack_d;
  logic tamper_edge;
  logic clr_seen;
  always_comb begin
    word_d = word_q;
    st_d = st_q;
    case (st_q)
      DOWD_ST_LOAD: begin
        // Unimplemented bits forced to one regardless of what storage holds [R1]
        word_d = (nvm_word & `DOWD_IMPL_MASK) | `DOWD_UNIMPL_ONES; // [R8] [R6]
        st_d = DOWD_ST_RUN;
      end
      DOWD_ST_RUN: begin
        // Word frozen until the next reset [R8]
        st_d = DOWD_ST_RUN;
      end
      default: begin
        // Unused code keeps the word rather than reloading a changed storage value
        st_d = DOWD_ST_RUN;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_q <= `DOWD_ERASED_WORD;
      st_q <= DOWD_ST_LOAD;
    end else begin
      word_q <= word_d;
      st_q <= st_d;
    end
  end
  // ==========================================
  // Decoded controls, valid only once loaded
  logic loaded;
  assign loaded = (st_q != DOWD_ST_LOAD);
  always_comb begin
    ctrl.ref_on_alt_pins = word_q[`DOWD_REF_LOC_BIT]; // [R2]
    ctrl.key_wipe_enable = ~word_q[`DOWD_KEY_WIPE_BIT]; // [R3]
    ctrl.tamper_pin_enable = ~word_q[`DOWD_TAMPER_INPUT_PIN_DIS_BIT] & loaded; // [R4]
    ctrl.cmp_on_default_pins = word_q[`DOWD_CMP_LOC_BIT]; // [R5]
  end
  assign tamper_pin_in_use = ctrl.tamper_pin_enable;
  // ==========================================
  // Tamper pin: three-stage sync, low-active event once stages two and three agree
  always_comb begin
    tp_sync_d = {tp_sync_q[1:0], tamper_pin_raw};
    tp_level_d = tp_level_q;
    if (tp_sync_q[1] == tp_sync_q[2]) begin
      tp_level_d = tp_sync_q[2];
    end
  end
  assign tamper_edge = tp_level_q & ~tp_level_d & ctrl.tamper_pin_enable; // [R4]
  always_comb begin
    tamper_seen_d = tamper_seen_q;
    wipe_ack_d = 1'b0;
    // Event in the clearing cycle wins over the clear
    tamper_seen_d = tamper_edge | (tamper_seen_q & ~clr_seen);
    // One-cycle erase pulse per event when wiping is enabled
    wipe_ack_d = tamper_edge & ctrl.key_wipe_enable; // [R3]
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tp_sync_q <= 3'h7;
      tp_level_q <= 1'b1;
      tamper_seen_q <= 1'b0;
      wipe_ack_q <= 1'b0;
    end else begin
      tp_sync_q <= tp_sync_d;
      tp_level_q <= tp_level_d;
      tamper_seen_q <= tamper_seen_d;
      wipe_ack_q <= wipe_ack_d;
    end
  end
  assign key_ram_erase = wipe_ack_q;
  // ==========================================
  // AXI4-Lite slave; the options word is read-only, writes get SLVERR except to the status register, which get OKAY
  logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d;
  logic rvalid_q, rvalid_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic w_clr_q, w_clr_d;
  assign awready = ~aw_have_q & ~bvalid_q;
  assign wready = ~w_have_q & ~bvalid_q;
  assign arready = ~rvalid_q;
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    aw_addr_d = aw_addr_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    w_clr_d = w_clr_q;
    clr_seen = 1'b0;
    if (awvalid && awready) begin
      aw_have_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_have_d = 1'b1;
      // Write data may change once taken, so the clear bit is kept here
      w_clr_d = wdata[0] & wstrb[0];
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_have_q && w_have_q && !bvalid_q) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `DOWD_RESP_SLVERR;
      // Status register: write one to bit 0 clears the sticky tamper flag
      if (aw_addr_q == `DOWD_STATUS_OFFS) begin
        bresp_d = `DOWD_RESP_OKAY;
        clr_seen = w_clr_q;
      end
    end
  end
  logic tamper_flag;
  assign tamper_flag = tamper_seen_q;
  always_comb begin
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d = `DOWD_RESP_OKAY;
      case (araddr)
        `DOWD_OPT_WORD_OFFS: rdata_d = {8'h00, word_q}; // [R6] [R1]
        `DOWD_CONTROL_OFFS: rdata_d = {28'h0000000, ctrl};
        `DOWD_STATUS_OFFS: rdata_d = {30'h0000000, loaded, tamper_flag};
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = `DOWD_RESP_SLVERR;
        end
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_clr_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h00000000;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      aw_addr_q <= aw_addr_d;
      w_clr_q <= w_clr_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  // ==========================================
  // Checks
  unimpl_ones_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    loaded |-> ((word_q | `DOWD_IMPL_MASK) == `DOWD_ERASED_WORD))
    else $error("unimplemented bit not one");
  ref_route_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    $rose(loaded) |-> ctrl.ref_on_alt_pins == $past(nvm_word[`DOWD_REF_LOC_BIT]))
    else $error("reference routing mismatch");
  wipe_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    tamper_edge && !word_q[`DOWD_KEY_WIPE_BIT] |=> key_ram_erase)
    else $error("key erase missing");
  no_wipe_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    key_ram_erase |-> $past(ctrl.key_wipe_enable))
    else $error("erase while wipe disabled");
  tamper_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    word_q[`DOWD_TAMPER_INPUT_PIN_DIS_BIT] |-> !tamper_pin_in_use && !tamper_edge)
    else $error("tamper pin active while disabled");
  cmp_route_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
    $rose(loaded) |-> ctrl.cmp_on_default_pins == $past(nvm_word[`DOWD_CMP_LOC_BIT]))
    else $error("comparator routing mismatch");
  word_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
    arvalid && arready && araddr == `DOWD_OPT_WORD_OFFS |=> rvalid && rdata[23:0] == $past(word_q))
    else $error("word readback wrong");
  word_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
    loaded |=> $stable(word_q) && loaded)
    else $error("word changed before reset");
endmodule

/* dowd_decoder_test.sv */
// Self-checking bench for the options word decoder: reset, register reads and writes, tamper pulses.
// Assumes the decoder, its package and its defines header compile first.
`timescale 1ns/1ps
`include "dowd_defines.svh"
module dowd_decoder_test;
  import dowd_pkg::*;
  logic aclk = 0, aresetn = 0, tamper_pin_raw = 1;
  logic [23:0] nvm_word = 24'h000000;
  dowd_ctrl_t ctrl;
  logic tamper_pin_in_use, key_ram_erase, awready, wready, bvalid, arready, rvalid;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, r;
  logic [23:0] w;
  logic [31:0] seed = 32'h2708;
  int miscompares = 0, n_tests = 0, k, n;
  always #10 aclk = ~aclk;
  dowd_decoder dut_u (.aclk(aclk), .aresetn(aresetn), .nvm_word(nvm_word), .tamper_pin_raw(tamper_pin_raw),
    .ctrl(ctrl), .tamper_pin_in_use(tamper_pin_in_use), .key_ram_erase(key_ram_erase), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // ==========================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [3:0] exp_ctrl(input logic [23:0] v);
    return {v[4], ~v[3], ~v[2], v[1]};
  endfunction
  task automatic wrap_up();
    $display("Counts: %0d compares, %0d mismatches", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hang();
    miscompares++;
    $display("MISMATCH bus wait expected answer seen none");
    wrap_up();
  endtask
  // Reads and writes hold every request until its own ready is sampled high
  task automatic rd(input logic [7:0] a, output logic [31:0] dd, output logic [1:0] rr);
    int i;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    i = 0;
    do begin @(posedge aclk); i++; end while (arready !== 1'b1 && i < 50);
    arvalid <= 0;
    while (rvalid !== 1'b1 && i < 100) begin @(posedge aclk); i++; end
    if (i >= 100) hang();
    dd = rdata;
    rr = rresp;
    rready <= 0;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dd, output logic [1:0] rr);
    int i;
    logic ta, tw;
    awaddr <= a;
    wdata <= dd;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    ta = 0;
    tw = 0;
    i = 0;
    do begin
      @(posedge aclk);
      i++;
      if (awready === 1'b1) begin ta = 1; awvalid <= 0; end
      if (wready === 1'b1 && !tw) begin tw = 1; wvalid <= 0; end
    end while (!(ta && tw) && i < 50);
    while (bvalid !== 1'b1 && i < 100) begin @(posedge aclk); i++; end
    if (i >= 100) hang();
    rr = bresp;
    bready <= 0;
    @(posedge aclk);
  endtask
  // ==========================================
  // One round per options word, corner values first
  task automatic round(input logic [23:0] v);
    int j;
    aresetn <= 0;
    nvm_word <= v;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    repeat (3) @(posedge aclk);
    nvm_word <= ~v;
    repeat (3) @(posedge aclk);
    chk("ctrl", {28'h0, ctrl}, {28'h0, exp_ctrl(v)});
    chk("pin_in_use", {31'h0, tamper_pin_in_use}, {31'h0, ~v[2]});
    rd(`DOWD_OPT_WORD_OFFS, d, r);
    chk("word", d, {8'h00, (v & `DOWD_IMPL_MASK) | `DOWD_UNIMPL_ONES});
    chk("word_resp", {30'h0, r}, {30'h0, `DOWD_RESP_OKAY});
    wr(`DOWD_OPT_WORD_OFFS, 32'h0, r);
    chk("word_wr_resp", {30'h0, r}, {30'h0, `DOWD_RESP_SLVERR});
    rd(`DOWD_OPT_WORD_OFFS, d, r);
    chk("word_kept", d[23:0], (v & `DOWD_IMPL_MASK) | `DOWD_UNIMPL_ONES);
    rd(8'h0C, d, r);
    chk("unmapped", {d[29:0], r}, {30'h0, `DOWD_RESP_SLVERR});
    tamper_pin_raw <= 0;
    n = 0;
    for (j = 0; j < 12; j++) begin @(posedge aclk); n += key_ram_erase; end
    chk("erase_pulses", n, {31'h0, ~v[3] & ~v[2]});
    chk("ctrl_held", {28'h0, ctrl}, {28'h0, exp_ctrl(v)});
    rd(`DOWD_CONTROL_OFFS, d, r);
    chk("ctrl_reg", d, {28'h0, exp_ctrl(v)});
    rd(`DOWD_STATUS_OFFS, d, r);
    chk("status", d, {30'h0, 1'b1, ~v[2]});
    wr(`DOWD_STATUS_OFFS, 32'h1, r);
    chk("clear_resp", {30'h0, r}, {30'h0, `DOWD_RESP_OKAY});
    rd(`DOWD_STATUS_OFFS, d, r);
    chk("status_clr", d, 32'h00000002);
    wr(`DOWD_CONTROL_OFFS, 32'h0, r);
    chk("ctrl_wr_resp", {30'h0, r}, {30'h0, `DOWD_RESP_SLVERR});
    tamper_pin_raw <= 1;
    repeat (4) @(posedge aclk);
    $display("Round done for word %h", v);
  endtask
  initial begin
    round(24'h000000); // Smallest package keeps bit 4 at zero
    round(24'hFFFFFF);
    round(24'h000012);
    for (k = 0; k < 12; k++) begin
      seed = xs(seed);
      w = seed[23:0];
      round(w);
    end
    wrap_up();
  end
endmodule
